// ---- src/btsc_ctrl.v ----
// Burst test operating state control: stop, pause and run.
// Assumes software on the strobe port and pins from outside the clock domain.
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "btsc_defs.vh"
module btsc_ctrl #(
  parameter PAUSE_TO_CYC = `BTSC_PAUSE_TO_CYC,
  parameter SEC_CYC      = `BTSC_SEC_CYC
) (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        equipmentFaultInput,
  input  wire        externalBurstTrigger,
  input  wire        interlockClosed,
  input  wire [3:0]  regAddr,
  input  wire [31:0] regWdata,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [31:0] regRdata,
  output reg         hvEnable,
  output reg         eutPowerEnable,
  output reg         burstSync,
  output reg         burstStart,
  output reg         stopLamp,
  output reg  [4:0]  couplingEnable
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [2:0] ST_STOP  = 3'b001;
  localparam [2:0] ST_PAUSE = 3'b010;
  localparam [2:0] ST_RUN   = 3'b100;
  localparam [1:0] ED_IDLE  = 2'b01;
  localparam [1:0] ED_EDIT  = 2'b10;
  localparam [31:0] EDIT_TO_CYC = `BTSC_EDIT_TO_S * `BTSC_CLK_HZ;

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  wire [2:0] pinSync;
  btsc_sync #(.W(3)) uSync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .asyncIn ({interlockClosed, externalBurstTrigger, equipmentFaultInput}),
    .syncOut (pinSync)
  );

  wire faultS = pinSync[0];
  wire trigS  = pinSync[1];
  wire intlS  = pinSync[2];

  reg        trigPrev_q;
  reg        faultPrev_q;
  reg  [2:0] state_q;
  reg  [2:0] state_d;
  reg  [19:0] testTime_q;
  reg  [19:0] elapsed_q;
  reg  [31:0] secCnt_q;
  reg  [31:0] pauseCnt_q;
  reg  [15:0] repeat_q;
  reg  [31:0] repCnt_q;
  reg  [7:0]  syncCnt_q;
  reg  [7:0]  msg_q;
  reg         msgValid_q;
  reg  [1:0]  edState_q;
  reg  [2:0]  edSel_q;
  reg  [15:0] edWork_q;
  reg  [31:0] edTimer_q;
  reg  [15:0] param_q [0:7];

  function isCmd;
    input [31:0] data;
    input integer bitIdx;
    begin
      isCmd = data[bitIdx];
    end
  endfunction

  wire ctrlWr   = regWr && (regAddr == `BTSC_ADDR_CTRL);
  wire editWr   = regWr && (regAddr == `BTSC_ADDR_EDIT);
  wire trigEdge = trigS ^ trigPrev_q;
  wire faultRise = faultS && !faultPrev_q;
  wire secTick  = (secCnt_q == SEC_CYC - 1);
  wire timeUp   = (elapsed_q >= testTime_q);
  wire repTick  = (repCnt_q == {16'h0000, repeat_q} * 25000 - 1);

  // ****************************************************************
  // Operating state machine
  // ****************************************************************
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_STOP: begin
        if (ctrlWr && intlS && !faultS && isCmd(regWdata, `BTSC_CMD_RUN))
          state_d = ST_RUN;
        else if (ctrlWr && intlS && !faultS && isCmd(regWdata, `BTSC_CMD_PAUSE))
          state_d = ST_PAUSE;
      end
      ST_PAUSE: begin
        if (ctrlWr && isCmd(regWdata, `BTSC_CMD_RUN))
          state_d = ST_RUN;
        if (pauseCnt_q == PAUSE_TO_CYC - 1)
          state_d = ST_STOP;
      end
      ST_RUN: begin
        if (ctrlWr && isCmd(regWdata, `BTSC_CMD_PAUSE))
          state_d = ST_PAUSE;
        if (timeUp)
          state_d = ST_STOP;
      end
      default: state_d = ST_STOP;
    endcase
    if (ctrlWr && isCmd(regWdata, `BTSC_CMD_STOP))
      state_d = ST_STOP;
    if (faultS || !intlS)
      state_d = ST_STOP;
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      state_q     <= ST_STOP;
      trigPrev_q  <= 1'b0;
      faultPrev_q <= 1'b0;
      secCnt_q    <= 32'h00000000;
      pauseCnt_q  <= 32'h00000000;
      elapsed_q   <= 20'h00000;
      repCnt_q    <= 32'h00000000;
      burstStart  <= 1'b0;
      syncCnt_q   <= 8'h00;
      burstSync   <= 1'b0;
    end else begin
      state_q     <= state_d;
      trigPrev_q  <= trigS;
      faultPrev_q <= faultS;
      burstStart  <= 1'b0;
      secCnt_q    <= (state_q == ST_STOP || secTick) ? 32'h00000000 : secCnt_q + 32'h00000001;
      if (state_q != ST_STOP && secTick)
        elapsed_q <= elapsed_q + 20'h00001;
      if (state_q == ST_STOP && state_d != ST_STOP)
        elapsed_q <= 20'h00000;
      if (state_q == ST_PAUSE && state_d == ST_STOP && pauseCnt_q == PAUSE_TO_CYC - 1)
        elapsed_q <= 20'h00000;
      if (state_q == ST_PAUSE && !trigEdge)
        pauseCnt_q <= pauseCnt_q + 32'h00000001;
      else
        pauseCnt_q <= 32'h00000000;
      // A package is only started when the state is kept, so a start never meets stop or a mode change.
      if (state_q == ST_PAUSE && trigEdge && state_d == ST_PAUSE)
        burstStart <= 1'b1;
      if (state_q == ST_RUN) begin
        repCnt_q <= repTick ? 32'h00000000 : repCnt_q + 32'h00000001;
        if (repCnt_q == 32'h00000000 && state_d == ST_RUN)
          burstStart <= 1'b1;
      end else begin
        repCnt_q <= 32'h00000000;
      end
      if (burstStart) begin
        syncCnt_q <= `BTSC_SYNC_LEN;
        burstSync <= 1'b1;
      end else if (syncCnt_q != 8'h00) begin
        syncCnt_q <= syncCnt_q - 8'h01;
        burstSync <= (syncCnt_q != 8'h01);
      end
    end
  end

  // ****************************************************************
  // Enables and lamp
  // ****************************************************************
  always @(posedge clk) begin
    if (sys_rst) begin
      hvEnable       <= 1'b0;
      eutPowerEnable <= 1'b0;
      stopLamp       <= 1'b1;
      msg_q          <= 8'h00;
      msgValid_q     <= 1'b0;
    end else begin
      hvEnable <= (state_d != ST_STOP) && intlS && !faultS;
      stopLamp <= (state_d == ST_STOP);
      if (ctrlWr && isCmd(regWdata, `BTSC_CMD_EUTP_ON) && intlS && !faultS)
        eutPowerEnable <= 1'b1;
      if (ctrlWr && isCmd(regWdata, `BTSC_CMD_EUTP_OFF))
        eutPowerEnable <= 1'b0;
      if (faultS || !intlS) begin
        hvEnable       <= 1'b0;
        eutPowerEnable <= 1'b0;
      end
      if (regRd && regAddr == `BTSC_ADDR_MSG)
        msgValid_q <= 1'b0;
      if (edState_q == ED_EDIT && edTimer_q == EDIT_TO_CYC - 1) begin
        msg_q      <= `BTSC_MSG_NOCONF;
        msgValid_q <= 1'b1;
      end
      if (faultRise) begin
        msg_q      <= `BTSC_MSG_FAULT;
        msgValid_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Settings and parameter editing
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : gParam
      always @(posedge clk) begin
        if (sys_rst)
          param_q[gi] <= 16'h0000;
        else if (edState_q == ED_EDIT && edSel_q == gi && editWr && isCmd(regWdata, `BTSC_ED_ENTER))
          param_q[gi] <= edWork_q;
      end
    end
  endgenerate

  always @(posedge clk) begin
    if (sys_rst) begin
      testTime_q     <= `BTSC_TTIME_RST;
      repeat_q       <= `BTSC_REPEAT_RST;
      couplingEnable <= 5'h00;
      edState_q      <= ED_IDLE;
      edSel_q        <= 3'h0;
      edWork_q       <= 16'h0000;
      edTimer_q      <= 32'h00000000;
    end else begin
      if (regWr && regAddr == `BTSC_ADDR_TTIME)
        testTime_q <= regWdata[19:0];
      if (regWr && regAddr == `BTSC_ADDR_REPEAT)
        repeat_q <= regWdata[15:0];
      if (regWr && regAddr == `BTSC_ADDR_COUPLE)
        couplingEnable <= regWdata[4:0];
      case (edState_q)
        ED_IDLE: begin
          edTimer_q <= 32'h00000000;
          if (editWr && isCmd(regWdata, `BTSC_ED_SELECT)) begin
            edSel_q   <= regWdata[10:8];
            edWork_q  <= param_q[regWdata[10:8]];
            edState_q <= ED_EDIT;
          end
        end
        ED_EDIT: begin
          edTimer_q <= edTimer_q + 32'h00000001;
          if (editWr && isCmd(regWdata, `BTSC_ED_UP))
            edWork_q <= edWork_q + 16'h0001;
          else if (editWr && isCmd(regWdata, `BTSC_ED_DOWN))
            edWork_q <= edWork_q - 16'h0001;
          if (editWr && isCmd(regWdata, `BTSC_ED_ENTER))
            edState_q <= ED_IDLE;
          else if (edTimer_q == EDIT_TO_CYC - 1) begin
            edWork_q  <= param_q[edSel_q];
            edState_q <= ED_IDLE;
          end
        end
        default: edState_q <= ED_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  always @(posedge clk) begin
    if (sys_rst) begin
      regRdata <= 32'h00000000;
    end else if (regRd) begin
      case (regAddr)
        `BTSC_ADDR_STATUS:  regRdata <= {22'h000000, edState_q[1], eutPowerEnable, hvEnable,
                                          intlS, faultS, msgValid_q, 1'b0, state_q};
        `BTSC_ADDR_TTIME:   regRdata <= {12'h000, testTime_q};
        `BTSC_ADDR_ELAPSED: regRdata <= {12'h000, elapsed_q};
        `BTSC_ADDR_REPEAT:  regRdata <= {16'h0000, repeat_q};
        `BTSC_ADDR_COUPLE:  regRdata <= {27'h0000000, couplingEnable};
        `BTSC_ADDR_EDIT:    regRdata <= {13'h0000, edSel_q, edWork_q};
        `BTSC_ADDR_PARAM:   regRdata <= {16'h0000, param_q[edSel_q]};
        `BTSC_ADDR_MSG:     regRdata <= {24'h000000, msg_q};
        default:            regRdata <= 32'h00000000;
      endcase
    end else begin
      regRdata <= 32'h00000000;
    end
  end

endmodule // btsc_ctrl

// ---- src/btsc_defs.vh ----
// Constants for the burst test state control block.
// Assumes a 25 MHz system clock and a plain strobe register port.
//
// Contract
// - External trigger honoured only in pause
// - One burst package per trigger edge
// - Sync output marks each burst package
// - Fault input forces stop, message 115
// - Fault drops high voltage and equipment power
// - Stop keeps high voltage off, settings editable
// - Run or pause from stop enables high voltage
// - Green stop lamp lit in stop
// - Open interlock holds both enables off
// - Pause keeps high voltage, waits, counts time
// - Two minutes without trigger returns to stop
// - Trigger timeout clears test time counter
// - Run generates packages repeatedly by itself
// - Test time expiry in run stops
// - Select, adjust, enter commits, back to options
// - Unconfirmed edit restores value, shows message
// - Separate enable for each coupling relay
// - Open interlock refuses run/pause, forces stop
// - Open interlock switches equipment power off
`ifndef BTSC_DEFS_VH
`define BTSC_DEFS_VH

`define BTSC_CLK_HZ        25000000
`define BTSC_PAUSE_TO_S    120
`define BTSC_PAUSE_TO_CYC  (`BTSC_PAUSE_TO_S * `BTSC_CLK_HZ)
`define BTSC_SEC_CYC       `BTSC_CLK_HZ
`define BTSC_EDIT_TO_S     30
`define BTSC_SYNC_LEN      8'h10

`define BTSC_ADDR_CTRL     4'h0
`define BTSC_ADDR_STATUS   4'h1
`define BTSC_ADDR_TTIME    4'h2
`define BTSC_ADDR_ELAPSED  4'h3
`define BTSC_ADDR_REPEAT   4'h4
`define BTSC_ADDR_COUPLE   4'h5
`define BTSC_ADDR_EDIT     4'h6
`define BTSC_ADDR_PARAM    4'h7
`define BTSC_ADDR_MSG      4'h8

`define BTSC_CMD_STOP      0
`define BTSC_CMD_RUN       1
`define BTSC_CMD_PAUSE     2
`define BTSC_CMD_EUTP_ON   3
`define BTSC_CMD_EUTP_OFF  4

`define BTSC_ED_SELECT     0
`define BTSC_ED_UP         1
`define BTSC_ED_DOWN       2
`define BTSC_ED_ENTER      3

`define BTSC_MSG_FAULT     8'h73
`define BTSC_MSG_NOCONF    8'h01
`define BTSC_TTIME_RST     20'h0003C
`define BTSC_REPEAT_RST    16'h1D4C
`define BTSC_NUM_COUPLE    5

`endif

// ---- src/btsc_sync.v ----
// Two-flop synchroniser for asynchronous pin inputs.
// Assumes the pins are quasi-static against the 25 MHz clock.
`timescale 1ns/1ps
module btsc_sync #(
  parameter W = 3
) (
  input  wire         clk,
  input  wire         sys_rst,
  input  wire [W-1:0] asyncIn,
  output reg  [W-1:0] syncOut
);
  reg [W-1:0] meta_q;

  always @(posedge clk) begin
    if (sys_rst) begin
      meta_q  <= {W{1'b0}};
      syncOut <= {W{1'b0}};
    end else begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule // btsc_sync

// ---- verif/btsc_props.sv ----
// Checker for the burst test state control block.
// Assumes it is bound to btsc_ctrl and sees only its ports.
`timescale 1ns/1ps
module btsc_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic equipmentFaultInput,
  input wire logic interlockClosed,
  input wire logic hvEnable,
  input wire logic eutPowerEnable,
  input wire logic burstSync,
  input wire logic burstStart,
  input wire logic stopLamp
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_stopHvOff; stopLamp |-> !hvEnable; endproperty
  a_stopHvOff: assert property (p_stopHvOff) else $error("hv on in stop");
  property p_activeHvOn; !stopLamp |-> hvEnable; endproperty
  a_activeHvOn: assert property (p_activeHvOn) else $error("hv off while active");
  property p_hvRise; $rose(hvEnable) |-> $fell(stopLamp); endproperty
  a_hvRise: assert property (p_hvRise) else $error("hv rose outside a start");
  // Five samples cover the two synchroniser flops and the output register.
  property p_fault; equipmentFaultInput[*5] |-> stopLamp && !hvEnable && !eutPowerEnable; endproperty
  a_fault: assert property (p_fault) else $error("fault did not stop");
  property p_lockOpen; !interlockClosed[*5] |-> stopLamp && !hvEnable && !eutPowerEnable; endproperty
  a_lockOpen: assert property (p_lockOpen) else $error("open loop left power on");
  property p_startOne; burstStart |=> !burstStart; endproperty
  a_startOne: assert property (p_startOne) else $error("start longer than one cycle");
  property p_startNotStop; burstStart |-> !stopLamp; endproperty
  a_startNotStop: assert property (p_startNotStop) else $error("package in stop");
  property p_syncLen; burstStart |=> burstSync[*8] ##1 burstSync[*8]; endproperty
  a_syncLen: assert property (p_syncLen) else $error("sync too short");
  property p_syncCause; $rose(burstSync) |-> $past(burstStart); endproperty
  a_syncCause: assert property (p_syncCause) else $error("sync without package");
  c_burst: cover property (burstStart);
  c_leave: cover property ($fell(stopLamp));
  c_fault: cover property (equipmentFaultInput ##5 stopLamp);
endmodule // btsc_props

// ---- verif/btsc_partner.sv ----
// Model of the trigger source and the equipment fault monitor.
// Assumes bench requests on clk; pins move off the edge as async sources.
`timescale 1ns/1ps
module btsc_partner (
  input  wire logic clk,
  input  wire logic edgeReq,
  input  wire logic faultReq,
  output logic      extTrig,
  output logic      faultPin
);
  initial begin
    extTrig = 1'b0;
    faultPin = 1'b0;
  end
  // The 13 ns lag keeps pin changes unrelated to the sampling edge.
  always @(posedge clk) begin
    if (edgeReq) extTrig <= #13 ~extTrig;
    faultPin <= #13 faultReq;
  end
endmodule // btsc_partner

// ---- verif/tb_top.sv ----
// Self-checking bench for the burst test state control block.
// Assumes design, checker and partner model are compiled before it.
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        interlockClosed = 1'b1;
  logic        edgeReq = 1'b0;
  logic        faultReq = 1'b0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [3:0]  regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic [31:0] rdv;
  wire         extTrig, faultPin, hvEnable, eutPowerEnable, burstSync, burstStart, stopLamp;
  wire  [31:0] regRdata;
  wire  [4:0]  couplingEnable;
  int          bad_count = 0, total_checks = 0, cyc = 0, starts = 0, base = 0;
  // Row: address, write flag, write data, expected read.
  logic [68:0] rows [0:7] = '{{4'h2, 1'b0, 32'h0, 32'h3C}, {4'h4, 1'b0, 32'h0, 32'h1D4C},
    {4'h1, 1'b0, 32'h0, 32'h41}, {4'h9, 1'b1, 32'h55, 32'h0}, {4'h5, 1'b1, 32'h15, 32'h15},
    {4'h5, 1'b1, 32'h0A, 32'h0A}, {4'h2, 1'b1, 32'hBB8, 32'hBB8}, {4'h4, 1'b1, 32'h1, 32'h1}};

  btsc_ctrl #(.PAUSE_TO_CYC(200), .SEC_CYC(10)) DUT (.clk(clk), .sys_rst(sys_rst),
    .equipmentFaultInput(faultPin), .externalBurstTrigger(extTrig), .interlockClosed(interlockClosed),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .hvEnable(hvEnable), .eutPowerEnable(eutPowerEnable), .burstSync(burstSync),
    .burstStart(burstStart), .stopLamp(stopLamp), .couplingEnable(couplingEnable));
  btsc_partner uPartner (.clk(clk), .edgeReq(edgeReq), .faultReq(faultReq), .extTrig(extTrig),
    .faultPin(faultPin));

  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (burstStart) starts <= starts + 1;
    if (cyc == 40000) begin
      bad_count++;
      summarize();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rdv = regRdata;
  endtask
  task trig;
    @(posedge clk);
    edgeReq <= 1'b1;
    @(posedge clk);
    edgeReq <= 1'b0;
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    wt(10);
    sys_rst <= 1'b0;
    chk(stopLamp, 1);
    wt(3);
    for (int i = 0; i < 8; i++) begin
      if (rows[i][64]) wr(rows[i][68:65], rows[i][63:32]);
      rd(rows[i][68:65]);
      chk(rdv, rows[i][31:0]);
    end
    chk(couplingEnable, 5'h0A);
    trig();
    wt(10);
    chk(starts - base, 0);
    wr(4'h0, 32'h4);
    wt(2);
    chk({stopLamp, hvEnable}, 2'b01);
    trig();
    wt(30);
    trig();
    wt(30);
    chk(starts - base, 2);
    rd(4'h3);
    chk(rdv > 32'h3, 1);
    chk(stopLamp, 0);
    wt(210);
    chk(stopLamp, 1);
    rd(4'h3);
    chk(rdv, 0);
    // Run lasts 3000 s of 10 cycles with a package every 25000 cycles.
    base = starts;
    wr(4'h0, 32'h2);
    wt(100);
    trig();
    wt(29000);
    chk(starts - base, 2);
    chk(stopLamp, 0);
    wt(1200);
    chk(stopLamp, 1);
    // Select parameter 2, step it up twice and commit it.
    wr(4'h6, 32'h201);
    wr(4'h6, 32'h2);
    wr(4'h6, 32'h2);
    wr(4'h6, 32'h8);
    rd(4'h7);
    chk(rdv, 32'h2);
    wr(4'h0, 32'h8);
    wt(2);
    chk({hvEnable, eutPowerEnable}, 2'b01);
    wr(4'h0, 32'h4);
    wt(2);
    faultReq <= 1'b1;
    wt(8);
    chk({stopLamp, hvEnable, eutPowerEnable}, 3'b100);
    rd(4'h8);
    chk(rdv, 32'h73);
    faultReq <= 1'b0;
    interlockClosed <= 1'b0;
    wt(6);
    wr(4'h0, 32'hA);
    wt(4);
    chk({stopLamp, hvEnable, eutPowerEnable}, 3'b100);
    interlockClosed <= 1'b1;
    wt(6);
    wr(4'h0, 32'hA);
    wt(4);
    chk({stopLamp, hvEnable, eutPowerEnable}, 3'b011);
    interlockClosed <= 1'b0;
    wt(6);
    chk({stopLamp, hvEnable, eutPowerEnable}, 3'b100);
    summarize();
  end
endmodule // tb_top

bind btsc_ctrl btsc_props uProps (.clk, .sys_rst, .equipmentFaultInput, .interlockClosed, .hvEnable,
  .eutPowerEnable, .burstSync, .burstStart, .stopLamp);
